// ==== design/bio_exec.sv ====
// Functional notes
// - Long jump loads its 11-bit literal into program counter bits 10..0.
// - Long jump fills counter bits 14..11 from page latch bits 6..3.
// - Long jump lasts two instruction cycles and keeps every flag.
// - Increment-skip adds one, writes destination, never touches the zero flag.
// - Nonzero increment-skip result runs next; zero result runs a no-operation instead.
// - Plain increment adds one, writes destination, updates the zero flag.
// - Destination bit low writes accumulator, high writes the file register.
// - Literal OR merges accumulator with 8-bit literal into accumulator, updates zero.
// - File OR merges accumulator with file register into destination, updates zero.
`timescale 1ns/100ps
module bio_exec (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Instruction request
  input wire logic instrValid,
  input wire logic [bio_pkg::BIO_INSTR_W-1:0] instrWord,
  output logic ready,
  // Core state
  input wire logic [bio_pkg::BIO_PAGE_W-1:0] pageLatch,
  output logic [bio_pkg::BIO_PC_W-1:0] pc,
  output logic [bio_pkg::BIO_DATA_W-1:0] acc,
  output logic zeroFlag,
  output logic nopCycle,
  // File register port
  output logic [bio_pkg::BIO_FADDR_W-1:0] fileAddr,
  input wire logic [bio_pkg::BIO_DATA_W-1:0] fileRdData,
  output logic fileWrEn,
  output logic [bio_pkg::BIO_DATA_W-1:0] fileWrData
);
  import bio_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} bio_state_t;

  bio_state_t state;
  bio_state_t next_state;
  bio_op_t op;
  logic destFile;
  logic [BIO_LIT11_W-1:0] operand;

  wire logic take = ready && instrValid;
  wire logic inExec = (state == ST_EXEC);
  wire logic [2:0] opField = instrWord[BIO_OPC_MSB:BIO_OPC_LSB];
  wire logic legalOp = (opField <= 3'h5);
  // Unused codes retire as a no-operation rather than stalling the core
  wire bio_op_t decOp = legalOp ? bio_op_t'(opField) : NO_OPERATION;
  wire logic isJump = (op == LONG_JUMP_OP);

  bio_alu_if aluBus ();

  assign aluBus.op = op;
  assign aluBus.destFile = destFile;
  assign aluBus.acc = acc;
  assign aluBus.fileData = fileRdData;
  assign aluBus.literal = operand[BIO_DATA_W-1:0];

  bio_alu u_alu (
    .io(aluBus.alu)
  );

  wire logic twoCycle = isJump || aluBus.skip;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = twoCycle ? ST_FLUSH : ST_IDLE;
      end
      ST_FLUSH: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  wire logic [BIO_PC_W-1:0] jumpTarget = {pageLatch[BIO_PAGE_MSB:BIO_PAGE_LSB], operand};
  wire logic [BIO_PC_W-1:0] pcStep = aluBus.skip ? BIO_PC_SKIP : BIO_PC_STEP;
  wire logic [BIO_PC_W-1:0] next_pc = !inExec ? pc : (isJump ? jumpTarget : pc + pcStep);
  wire logic [BIO_DATA_W-1:0] next_acc = (inExec && aluBus.toAcc) ? aluBus.result : acc;
  // Long jump and increment-skip leave the flag alone
  wire logic next_zeroFlag = (inExec && aluBus.flagUpd) ? aluBus.zero : zeroFlag;
  wire logic next_fileWrEn = inExec && aluBus.toFile;
  wire logic next_ready = (next_state == ST_IDLE);
  wire logic next_nop = inExec && twoCycle;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      ready <= 1'b0;
      nopCycle <= 1'b0;
    end else begin
      state <= next_state;
      ready <= next_ready;
      nopCycle <= next_nop;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op <= NO_OPERATION;
      destFile <= 1'b0;
      operand <= '0;
      fileAddr <= BIO_FADDR_RESET;
    end else if (take) begin
      op <= decOp;
      destFile <= instrWord[BIO_DEST_BIT];
      operand <= instrWord[BIO_LIT11_W-1:0];
      fileAddr <= instrWord[BIO_FADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pc <= BIO_PC_RESET;
      acc <= BIO_ACC_RESET;
      zeroFlag <= 1'b0;
      fileWrEn <= 1'b0;
      fileWrData <= BIO_ZERO;
    end else begin
      pc <= next_pc;
      acc <= next_acc;
      zeroFlag <= next_zeroFlag;
      fileWrEn <= next_fileWrEn;
      fileWrData <= next_fileWrEn ? aluBus.result : fileWrData;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  wire logic exJump = inExec && (op == LONG_JUMP_OP);
  wire logic exSkipInc = inExec && (op == INCREMENT_SKIP_ZERO_OP);
  wire logic exInc = inExec && (op == INCREMENT_FILE_OP);
  wire logic exOrLit = inExec && (op == OR_LITERAL_ACC_OP);
  wire logic exOrFile = inExec && (op == OR_ACC_FILE_OP);

  property p_jump_low;
    exJump |=> pc[BIO_LIT11_W-1:0] == $past(operand);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong");

  property p_jump_page;
    exJump |=> pc[BIO_PC_W-1:BIO_LIT11_W] == $past(pageLatch[BIO_PAGE_MSB:BIO_PAGE_LSB]);
  endproperty
  a_jump_page: assert property (p_jump_page) else $error("jump page bits wrong");

  property p_jump_two;
    exJump |=> (nopCycle && !ready && $stable(zeroFlag) && $stable(acc)) ##1 (ready && !nopCycle);
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  property p_skip_flag;
    exSkipInc |=> $stable(zeroFlag);
  endproperty
  a_skip_flag: assert property (p_skip_flag) else $error("skip increment changed zero");

  property p_skip_zero;
    exSkipInc && (fileRdData == 8'hFF) |=> nopCycle && (pc == $past(pc) + BIO_PC_SKIP) ##1 ready;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero result did not skip");

  property p_skip_none;
    exSkipInc && (fileRdData != 8'hFF) |=> !nopCycle && ready && (pc == $past(pc) + BIO_PC_STEP);
  endproperty
  a_skip_none: assert property (p_skip_none) else $error("nonzero result skipped");

  property p_inc_zero;
    exInc |=> zeroFlag == ($past(fileRdData) == 8'hFF);
  endproperty
  a_inc_zero: assert property (p_inc_zero) else $error("increment zero flag wrong");

  property p_dest;
    // Result may equal the old accumulator, so compare values rather than test for change
    inExec && bio_is_file_op(op) |=> (fileWrEn == $past(destFile)) &&
      (acc == ($past(destFile) ? $past(acc) : $past(aluBus.result)));
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_or_lit;
    exOrLit |=> acc == ($past(acc) | $past(operand[BIO_DATA_W-1:0])) && zeroFlag == (acc == BIO_ZERO);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

  property p_or_file;
    exOrFile && destFile |=> fileWrData == ($past(acc) | $past(fileRdData)) && zeroFlag == (fileWrData == BIO_ZERO);
  endproperty
  a_or_file: assert property (p_or_file) else $error("file OR wrong");

  property p_addr;
    take |=> fileAddr == $past(instrWord[BIO_FADDR_W-1:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("file address not latched");

  c_jump: cover property (exJump ##2 take);
  c_skip: cover property (exSkipInc && aluBus.skip);
  c_or_zero: cover property (exOrLit && aluBus.zero);
endmodule // bio_exec

// ==== inc/bio_pkg.sv ====
package bio_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BIO_PC_W = 15;
  localparam int BIO_DATA_W = 8;
  localparam int BIO_FADDR_W = 7;
  localparam int BIO_INSTR_W = 14;
  localparam int BIO_LIT11_W = 11;
  localparam int BIO_PAGE_W = 7;
  // ----------------------------------------------------------------
  // Instruction word and page latch fields
  // ----------------------------------------------------------------
  localparam int BIO_OPC_MSB = 13;
  localparam int BIO_OPC_LSB = 11;
  localparam int BIO_DEST_BIT = 7;
  localparam int BIO_PAGE_MSB = 6;
  localparam int BIO_PAGE_LSB = 3;
  // ----------------------------------------------------------------
  // Reset values and steps
  // ----------------------------------------------------------------
  localparam logic [BIO_PC_W-1:0] BIO_PC_RESET = 15'h0000;
  localparam logic [BIO_PC_W-1:0] BIO_PC_STEP = 15'h0001;
  localparam logic [BIO_PC_W-1:0] BIO_PC_SKIP = 15'h0002;
  localparam logic [BIO_DATA_W-1:0] BIO_ACC_RESET = 8'h00;
  localparam logic [BIO_DATA_W-1:0] BIO_INC_STEP = 8'h01;
  localparam logic [BIO_DATA_W-1:0] BIO_ZERO = 8'h00;
  localparam logic [BIO_FADDR_W-1:0] BIO_FADDR_RESET = 7'h00;
  // ----------------------------------------------------------------
  // Operation codes (field BIO_OPC_MSB:BIO_OPC_LSB)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NO_OPERATION = 3'h0,
    LONG_JUMP_OP = 3'h1,
    INCREMENT_SKIP_ZERO_OP = 3'h2,
    INCREMENT_FILE_OP = 3'h3,
    OR_LITERAL_ACC_OP = 3'h4,
    OR_ACC_FILE_OP = 3'h5
  } bio_op_t;

  function automatic logic bio_is_file_op(input bio_op_t op);
    return (op == INCREMENT_SKIP_ZERO_OP) || (op == INCREMENT_FILE_OP) || (op == OR_ACC_FILE_OP);
  endfunction
endpackage

// ==== inc/bio_alu_if.sv ====
`timescale 1ns/100ps
interface bio_alu_if;
  import bio_pkg::*;
  bio_op_t op;
  logic destFile;
  logic [BIO_DATA_W-1:0] acc;
  logic [BIO_DATA_W-1:0] fileData;
  logic [BIO_DATA_W-1:0] literal;
  logic [BIO_DATA_W-1:0] result;
  logic zero;
  logic toFile;
  logic toAcc;
  logic flagUpd;
  logic skip;
  modport alu (input op, destFile, acc, fileData, literal,
               output result, zero, toFile, toAcc, flagUpd, skip);
  modport core (output op, destFile, acc, fileData, literal,
                input result, zero, toFile, toAcc, flagUpd, skip);
endinterface // bio_alu_if

// ==== design/bio_alu.sv ====
`timescale 1ns/100ps
module bio_alu (
  // Operands and results
  bio_alu_if.alu io
);
  import bio_pkg::*;

  wire logic [BIO_DATA_W-1:0] incSum = io.fileData + BIO_INC_STEP;
  wire logic [BIO_DATA_W-1:0] orLit = io.acc | io.literal;
  wire logic [BIO_DATA_W-1:0] orFile = io.acc | io.fileData;
  wire logic isOrLit = (io.op == OR_LITERAL_ACC_OP);
  wire logic isOrFile = (io.op == OR_ACC_FILE_OP);
  wire logic fileOp = bio_is_file_op(io.op);

  assign io.result = isOrLit ? orLit : (isOrFile ? orFile : incSum);
  assign io.zero = (io.result == BIO_ZERO);
  assign io.toFile = fileOp && io.destFile;
  assign io.toAcc = (fileOp && !io.destFile) || isOrLit;
  // Skipping increment never touches the zero flag
  assign io.flagUpd = (io.op == INCREMENT_FILE_OP) || isOrLit || isOrFile;
  assign io.skip = (io.op == INCREMENT_SKIP_ZERO_OP) && io.zero;
endmodule // bio_alu

// ==== sim/bio_exec_bench.sv ====
`timescale 1ns/100ps
module bio_exec_bench;
  import bio_pkg::*;
  // ------------------------------------------------------------
  // Signals and reference state
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic instrValid = 1'b0;
  logic [BIO_INSTR_W-1:0] instrWord = 14'h0000;
  logic [BIO_PAGE_W-1:0] pageLatch = 7'h00;
  logic ready;
  logic [BIO_PC_W-1:0] pc;
  logic [BIO_DATA_W-1:0] acc;
  logic zeroFlag;
  logic nopCycle;
  logic [BIO_FADDR_W-1:0] fileAddr;
  logic [BIO_DATA_W-1:0] fileRdData;
  logic fileWrEn;
  logic [BIO_DATA_W-1:0] fileWrData;
  logic [7:0] mem [128];
  int mmem [128];
  int mpc = 0;
  int macc = 0;
  int mz = 0;
  int badCount = 0;
  int testsRun = 0;
  logic [15:0] seed = 16'h0045;

  bio_exec i_bio_exec (.mclk(mclk), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord), .ready(ready),
    .pageLatch(pageLatch), .pc(pc), .acc(acc), .zeroFlag(zeroFlag), .nopCycle(nopCycle), .fileAddr(fileAddr),
    .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData));

  always #2 mclk = ~mclk;
  // Far-side register file answers at once
  assign fileRdData = mem[fileAddr];
  always @(posedge mclk) if (fileWrEn === 1'b1) mem[fileAddr] <= fileWrData;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic setFile(input int f, input int v);
    mem[f] = v[7:0];
    mmem[f] = v;
  endtask

  task automatic testDone;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One instruction: drive, update the model, wait for ready, compare
  task automatic run(input logic [13:0] w, input logic [6:0] pg);
    int op, f, d, r, cyc, no_operation, wr, n, sawNop, sawWr;
    op = w[13:11];
    f = w[6:0];
    d = w[7];
    r = -1;
    cyc = 1;
    no_operation = 0;
    wr = 0;
    @(posedge mclk);
    instrValid <= 1'b1;
    instrWord <= w;
    pageLatch <= pg;
    case (op)
      1: begin
        mpc = {pg[6:3], w[10:0]};
        cyc = 2;
        no_operation = 1;
      end
      2, 3: r = (mmem[f] + 1) & 255;
      4: begin
        macc = macc | w[7:0];
        mz = (macc == 0);
      end
      5: r = macc | mmem[f];
      default: ;
    endcase
    if (op != 1) mpc = (mpc + ((op == 2 && r == 0) ? 2 : 1)) & 32767;
    if (r >= 0) begin
      if (d) begin
        mmem[f] = r;
        wr = 1;
      end else macc = r;
      if (op != 2) mz = (r == 0);
      else if (r == 0) begin
        cyc = 2;
        no_operation = 1;
      end
    end
    @(posedge mclk);
    instrValid <= 1'b0;
    n = 0;
    sawNop = 0;
    sawWr = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      sawNop += (nopCycle === 1'b1);
      sawWr += (fileWrEn === 1'b1);
    end while (ready !== 1'b1 && n < 8);
    chk(16'(pc), 16'(mpc));
    chk(16'(acc), 16'(macc));
    chk(16'(zeroFlag), 16'(mz));
    // Write pulse lands in the bench file one edge later; the held write data stands now
    chk(16'(wr ? fileWrData : mem[f]), 16'(mmem[f]));
    chk(16'(n), 16'(cyc));
    chk(16'(sawNop), 16'(no_operation));
    chk(16'(sawWr), 16'(wr));
    if (r >= 0) chk(16'(fileAddr), 16'(f));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      setFile(i, seed[7:0]);
    end
    repeat (20) @(posedge mclk);
    chk(16'(pc), 16'h0000);
    chk(16'(acc), 16'h0000);
    chk(16'(zeroFlag), 16'h0000);
    nrst <= 1'b1;
    run(14'h2000, 7'h00);
    setFile(5, 255);
    run(14'h1885, 7'h00);
    run(14'h1085, 7'h00);
    setFile(6, 255);
    run(14'h1006, 7'h00);
    run(14'h0FFF, 7'h7F);
    // Random operands cycle through every op code, unused ones too
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      run({3'(i % 8), seed[10:0]}, seed[15:9]);
    end
    testDone;
  end

  initial begin
    #100000;
    badCount++;
    $display("watchdog expired at %0t", $time);
    testDone;
  end
endmodule // bio_exec_bench
